//--- inc/dma_mode_pkg.sv
// Purpose: shared constants and types for one external-request DMA channel
// Assumes: 32-bit register port, byte offsets four apart, 100 MHz MCLK
// Notes:   bit positions of the mode control word are fixed by the channel layout
package dma_mode_pkg;

  // ****************************************************************
  // register port
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_BLKSZ = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;

  // ****************************************************************
  // mode control word fields
  // ****************************************************************
  localparam int BIT_ACTIVE = 15;
  localparam int BIT_BEF = 14;
  localparam int BIT_RAKE = 13;
  localparam int BIT_TENDE = 12;
  localparam int BIT_SENSE = 11;
  localparam int BIT_MDS_HI = 9;
  localparam int BIT_MDS_LO = 8;

  localparam logic [1:0] MODE_EXT_NORMAL = 2'h2;
  localparam logic [1:0] MODE_EXT_BLOCK = 2'h3;

  // interrupt status and mask bits
  localparam int INT_END = 0;
  localparam int INT_BEF = 1;
  localparam int INT_W = 2;

  // ****************************************************************
  // values after reset
  // ****************************************************************
  localparam logic RST_FLAG = 1'b0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [INT_W-1:0] RST_INT = 2'h0;
  localparam logic [DATA_W-1:0] RST_RDATA = 32'h0000_0000;

  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_XFER = 2'h3
  } state_t;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed
  {
    logic strobe;
    logic [31:0] src;
    logic [31:0] dst;
  } beat_t;

endpackage

//--- verilog/req_sense.sv
// Purpose: detects a transfer request on the active-low external request pin
// Assumes: pin already synchronous to clk
// Notes:   first request after arming is always taken on a low level
module req_sense
(
  input wire logic clk,       // system clock
  input wire logic rst_b,     // async reset, active low
  input wire logic req_b,     // external request pin, active low
  input wire logic edge_mode, // 1 falling edge, 0 low level
  input wire logic arm,       // channel just enabled
  input wire logic take,      // request consumed this cycle
  output logic hit            // a request is pending
);

  logic prev_q;
  logic fall_q;
  logic first_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prev_q <= 1'b1;
    else
      prev_q <= req_b;
  end

  // an edge seen in the same cycle as a level-taken first request is that request
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fall_q <= 1'b0;
    else if (arm)
      fall_q <= 1'b0;
    else if (prev_q && !req_b && !(take && first_q))
      fall_q <= 1'b1;
    else if (take)
      fall_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      first_q <= 1'b0;
    else if (arm)
      first_q <= 1'b1;
    else if (take)
      first_q <= 1'b0;
  end

  assign hit = (!edge_mode || first_q) ? !req_b : fall_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_level_sense: assert property (!edge_mode && !req_b |-> hit)
    else $error("low level not seen as request");
  a_first_level: assert property (first_q && !req_b && !arm |-> hit)
    else $error("first request not taken on low level");

endmodule // req_sense

//--- verilog/dma_mode_chan.sv
// Purpose: one external DMA channel with block error flag, pin enables, request sensing
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   pins are active low; a disabled pin sits high with its enable low-active off
//
// What this block does
// - NMI in block transfer aborts, sets error flag
// - after abort addresses point at next transfer
// - error flag clears by read-1 then write-0
// - flag, enables, sense select reset to zero
// - acknowledge enable bit gates acknowledge pin
// - end enable bit gates transfer-end pin
// - sense select: low level or falling edge
// - first request after enable is level sensed
// - reset, NMI, standby clear channel active
// - mode 10 or 11 means external request
//
// The plain strobed port and the register offsets were chosen for this implementation.
module dma_mode_chan
#(
  parameter int CNT_W = 16, // transfer counter width
  parameter int BLK_W = 8   // block size width
)
(
  input wire logic MCLK,                                  // 100 MHz system clock
  input wire logic RST_B,                                 // async reset, active low
  input wire logic [dma_mode_pkg::ADDR_W-1:0] ADDR,       // register byte address
  input wire logic [dma_mode_pkg::DATA_W-1:0] WDATA,      // write data
  input wire logic WR,                                    // write strobe
  input wire logic RD,                                    // read strobe
  output logic [dma_mode_pkg::DATA_W-1:0] RDATA,          // read data, cycle after RD
  input wire logic EXT_REQUEST_PIN_B,                     // external request, active low
  input wire logic NMI,                                   // non-maskable interrupt
  input wire logic STANDBY_B,                             // hardware standby, active low
  output logic REQ_ACK_PIN_B,                             // acknowledge/start, active low
  output logic REQ_ACK_OE_B,                              // acknowledge pin drive, low on
  output logic XFER_END_PIN_B,                            // transfer end, active low
  output logic XFER_END_OE_B,                             // end pin drive, low on
  output dma_mode_pkg::beat_t BEAT,                       // one data move per strobe
  output logic IRQ                                        // unmasked status pending
);

  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic logic sel(input logic [dma_mode_pkg::ADDR_W-1:0] a,
                               input logic [dma_mode_pkg::ADDR_W-1:0] ofs);
    sel = (a == ofs);
  endfunction

  dma_mode_pkg::bus_req_t bus;
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic wr_ctrl;
  logic rd_ctrl;
  logic wr_src;
  logic wr_dst;
  logic wr_count;
  logic wr_blksz;
  logic wr_istat;
  logic wr_imask;
  assign wr_ctrl = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_CTRL);
  assign rd_ctrl = bus.rd && sel(bus.addr, dma_mode_pkg::OFS_CTRL);
  assign wr_src = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_SRC);
  assign wr_dst = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_DST);
  assign wr_count = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_COUNT);
  assign wr_blksz = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_BLKSZ);
  assign wr_istat = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_ISTAT);
  assign wr_imask = bus.wr && sel(bus.addr, dma_mode_pkg::OFS_IMASK);

  // ****************************************************************
  // state
  // ****************************************************************
  dma_mode_pkg::state_t state_q;
  logic active_q;
  logic bef_q;
  logic bef_armed_q;
  logic rake_q;
  logic tende_q;
  logic sense_q;
  logic [1:0] mode_q;
  logic stop_pend_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic [CNT_W-1:0] count_q;
  logic [BLK_W-1:0] blksz_q;
  logic [BLK_W-1:0] blk_left_q;
  logic [dma_mode_pkg::INT_W-1:0] istat_q;
  logic [dma_mode_pkg::INT_W-1:0] imask_q;

  logic ext_mode;
  logic block_mode;
  logic stop;
  logic req_hit;
  logic take;
  logic arm;
  logic beat;
  logic last_beat;
  logic block_end;
  logic finish;
  logic nmi_abort;
  logic in_block;

  assign ext_mode = mode_q[1];
  assign block_mode = (mode_q == dma_mode_pkg::MODE_EXT_BLOCK);
  assign stop = NMI || !STANDBY_B;
  assign in_block = (state_q == dma_mode_pkg::ST_XFER) && block_mode;
  assign nmi_abort = NMI && in_block;
  assign take = (state_q == dma_mode_pkg::ST_WAIT) && active_q && !stop && req_hit;
  assign beat = (state_q == dma_mode_pkg::ST_XFER) && !stop;
  assign last_beat = (count_q == CNT_W'(1));
  assign block_end = (blk_left_q == BLK_W'(1));
  assign finish = beat && last_beat;
  assign arm = wr_ctrl && bus.wdata[dma_mode_pkg::BIT_ACTIVE] && !active_q;

  req_sense u_sense
  (
    .clk(MCLK),
    .rst_b(RST_B),
    .req_b(EXT_REQUEST_PIN_B),
    .edge_mode(sense_q),
    .arm(arm),
    .take(take),
    .hit(req_hit)
  );

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      state_q <= dma_mode_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        dma_mode_pkg::ST_IDLE:
          if (active_q && !stop)
            state_q <= ext_mode ? dma_mode_pkg::ST_WAIT : dma_mode_pkg::ST_XFER;
        dma_mode_pkg::ST_WAIT:
          if (stop || !active_q)
            state_q <= dma_mode_pkg::ST_IDLE;
          else if (take)
            state_q <= dma_mode_pkg::ST_XFER;
        dma_mode_pkg::ST_XFER:
          if (stop || finish)
            state_q <= dma_mode_pkg::ST_IDLE;
          else if (!ext_mode)
          begin
            if (!active_q)
              state_q <= dma_mode_pkg::ST_IDLE;
          end
          else if (block_end)
            state_q <= (stop_pend_q || !active_q) ? dma_mode_pkg::ST_IDLE
                                                  : dma_mode_pkg::ST_WAIT;
        default:
          state_q <= dma_mode_pkg::ST_IDLE;
      endcase
    end
  end

  // beats left in the current block; normal transfer is a block of one
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      blk_left_q <= '0;
    else if (take)
      blk_left_q <= block_mode ? blksz_q : BLK_W'(1);
    else if (beat && !block_end)
      blk_left_q <= blk_left_q - BLK_W'(1);
  end

  // ****************************************************************
  // channel active
  // ****************************************************************
  // a software stop during a block waits for the block to finish
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      active_q <= dma_mode_pkg::RST_FLAG;
    else if (stop)
      active_q <= 1'b0;
    else if (finish || (beat && block_end && stop_pend_q))
      active_q <= 1'b0;
    else if (wr_ctrl && bus.wdata[dma_mode_pkg::BIT_ACTIVE])
      active_q <= 1'b1;
    else if (wr_ctrl && !in_block)
      active_q <= 1'b0;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      stop_pend_q <= 1'b0;
    else if (state_q == dma_mode_pkg::ST_IDLE)
      stop_pend_q <= 1'b0;
    else if (wr_ctrl && in_block && !bus.wdata[dma_mode_pkg::BIT_ACTIVE])
      stop_pend_q <= 1'b1;
  end

  // ****************************************************************
  // block error flag
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      bef_armed_q <= 1'b0;
    else if (!bef_q)
      bef_armed_q <= 1'b0;
    else if (rd_ctrl)
      bef_armed_q <= 1'b1;
  end

  // set beats clear; a write of one is ignored
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      bef_q <= dma_mode_pkg::RST_FLAG;
    else if (nmi_abort)
      bef_q <= 1'b1;
    else if (wr_ctrl && !bus.wdata[dma_mode_pkg::BIT_BEF] && bef_armed_q)
      bef_q <= 1'b0;
  end

  // ****************************************************************
  // mode bits
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rake_q <= dma_mode_pkg::RST_FLAG;
      tende_q <= dma_mode_pkg::RST_FLAG;
      sense_q <= dma_mode_pkg::RST_FLAG;
      mode_q <= dma_mode_pkg::RST_MODE;
    end
    else if (wr_ctrl)
    begin
      rake_q <= bus.wdata[dma_mode_pkg::BIT_RAKE];
      tende_q <= bus.wdata[dma_mode_pkg::BIT_TENDE];
      sense_q <= bus.wdata[dma_mode_pkg::BIT_SENSE];
      mode_q <= bus.wdata[dma_mode_pkg::BIT_MDS_HI:dma_mode_pkg::BIT_MDS_LO];
    end
  end

  // ****************************************************************
  // address and count registers
  // ****************************************************************
  // addresses step on every beat, so an abort leaves the next addresses behind
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      src_q <= dma_mode_pkg::RST_ADDR;
      dst_q <= dma_mode_pkg::RST_ADDR;
    end
    else if (beat)
    begin
      src_q <= src_q + dma_mode_pkg::ADDR_STEP;
      dst_q <= dst_q + dma_mode_pkg::ADDR_STEP;
    end
    else
    begin
      if (wr_src)
        src_q <= bus.wdata;
      if (wr_dst)
        dst_q <= bus.wdata;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      count_q <= '0;
    else if (beat)
      count_q <= count_q - CNT_W'(1);
    else if (wr_count)
      count_q <= bus.wdata[CNT_W-1:0];
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      blksz_q <= BLK_W'(1);
    else if (wr_blksz)
      blksz_q <= bus.wdata[BLK_W-1:0];
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [dma_mode_pkg::INT_W-1:0] int_set;
  assign int_set = {nmi_abort, finish};

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      istat_q <= dma_mode_pkg::RST_INT;
    else if (wr_istat)
      istat_q <= (istat_q & ~bus.wdata[dma_mode_pkg::INT_W-1:0]) | int_set;
    else
      istat_q <= istat_q | int_set;
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      imask_q <= dma_mode_pkg::RST_INT;
    else if (wr_imask)
      imask_q <= bus.wdata[dma_mode_pkg::INT_W-1:0];
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      IRQ <= 1'b0;
    else
      IRQ <= |(istat_q & imask_q);
  end

  // ****************************************************************
  // pins and beat output
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REQ_ACK_PIN_B <= 1'b1;
      REQ_ACK_OE_B <= 1'b1;
      XFER_END_PIN_B <= 1'b1;
      XFER_END_OE_B <= 1'b1;
    end
    else
    begin
      REQ_ACK_PIN_B <= !(rake_q && take);
      REQ_ACK_OE_B <= !rake_q;
      XFER_END_PIN_B <= !(tende_q && finish);
      XFER_END_OE_B <= !tende_q;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      BEAT <= '0;
    else
      BEAT <= '{strobe: beat, src: src_q, dst: dst_q};
  end

  // ****************************************************************
  // register read
  // ****************************************************************
  logic [dma_mode_pkg::DATA_W-1:0] ctrl_word;
  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[dma_mode_pkg::BIT_ACTIVE] = active_q;
    ctrl_word[dma_mode_pkg::BIT_BEF] = bef_q;
    ctrl_word[dma_mode_pkg::BIT_RAKE] = rake_q;
    ctrl_word[dma_mode_pkg::BIT_TENDE] = tende_q;
    ctrl_word[dma_mode_pkg::BIT_SENSE] = sense_q;
    ctrl_word[dma_mode_pkg::BIT_MDS_HI:dma_mode_pkg::BIT_MDS_LO] = mode_q;
  end

  // unmapped addresses read as zero
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
      RDATA <= dma_mode_pkg::RST_RDATA;
    else if (!bus.rd)
      RDATA <= dma_mode_pkg::RST_RDATA;
    else
    begin
      case (bus.addr)
        dma_mode_pkg::OFS_CTRL: RDATA <= ctrl_word;
        dma_mode_pkg::OFS_SRC: RDATA <= src_q;
        dma_mode_pkg::OFS_DST: RDATA <= dst_q;
        dma_mode_pkg::OFS_COUNT: RDATA <= 32'(count_q);
        dma_mode_pkg::OFS_BLKSZ: RDATA <= 32'(blksz_q);
        dma_mode_pkg::OFS_ISTAT: RDATA <= 32'(istat_q);
        dma_mode_pkg::OFS_IMASK: RDATA <= 32'(imask_q);
        default: RDATA <= dma_mode_pkg::RST_RDATA;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  a_bef_on_nmi: assert property (nmi_abort |=> bef_q && state_q == dma_mode_pkg::ST_IDLE)
    else $error("nmi in block did not abort and flag");
  a_addr_held_abort: assert property (nmi_abort |=> src_q == $past(src_q) && !BEAT.strobe)
    else $error("addresses moved on abort");
  a_bef_clear_order: assert property ($fell(bef_q) |-> $past(bef_armed_q))
    else $error("error flag cleared without prior read");
  a_bef_write_one: assert property (!bef_q && !nmi_abort |=> !bef_q)
    else $error("error flag set without abort");
  // the default disable would mask this check for the whole reset, so it opts out
  a_reset_zero: assert property (@(posedge MCLK) disable iff (1'b0)
                                 !RST_B |-> !bef_q && !rake_q && !tende_q && !sense_q)
    else $error("mode flags not zero in reset");
  a_ack_gate: assert property (!rake_q |=> REQ_ACK_PIN_B && REQ_ACK_OE_B)
    else $error("acknowledge pin active while disabled");
  a_ack_pulse: assert property (rake_q && take |=> !REQ_ACK_PIN_B ##1 REQ_ACK_PIN_B)
    else $error("acknowledge pulse wrong");
  a_end_gate: assert property (!tende_q |=> XFER_END_PIN_B && XFER_END_OE_B)
    else $error("end pin active while disabled");
  a_stop_clears: assert property (stop |=> !active_q && state_q == dma_mode_pkg::ST_IDLE)
    else $error("channel still active after stop");
  a_ext_wait: assert property (state_q == dma_mode_pkg::ST_IDLE && active_q && !stop && ext_mode
                               |=> state_q == dma_mode_pkg::ST_WAIT)
    else $error("external mode did not wait for request");

endmodule // dma_mode_chan

//--- tb/ext_periph.sv
// Purpose: external peripheral that raises the DMA request pin
// Assumes: request line idles high through a pull-up
// Notes:   holds the request low for a commanded number of cycles
module ext_periph
(
  input wire logic clk,        // system clock
  input wire logic rst_b,      // reset, active low
  input wire logic go,         // start a request
  input wire logic [7:0] hold, // cycles to hold request low
  input wire logic ack_b,      // acknowledge pin
  input wire logic end_b,      // transfer-end pin
  output logic req_b,          // request pin, active low
  output logic [7:0] acks,     // acknowledge pulses seen
  output logic [7:0] ends      // end pulses seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left_q;

  // a released line goes back to the pull-up level
  assign req_b = (left_q == 8'h00);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_q <= 8'h00;
      acks <= 8'h00;
      ends <= 8'h00;
    end
    else
    begin
      if (go)
        left_q <= hold;
      else if (left_q != 8'h00)
        left_q <= left_q - 8'h01;
      if (ack_b == 1'b0)
        acks <= acks + 8'h01;
      if (end_b == 1'b0)
        ends <= ends + 8'h01;
    end
  end
endmodule // ext_periph

//--- tb/dma_mode_chan_test.sv
// Purpose: self-checking bench for the DMA channel mode flags
// Assumes: registers reached over the plain strobe port
// Notes:   the peripheral model drives the request pin
module dma_mode_chan_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] hold = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic nmi = 1'b0;
  logic standby_b = 1'b1;
  logic go = 1'b0;
  logic [31:0] rdata, d, last_src, last_dst;
  logic req_b, ack_b, ack_oe_b, end_b, end_oe_b, irq;
  logic [7:0] acks, ends, a0, e0;
  dma_mode_pkg::beat_t beat;
  int beats = 0;
  int b0 = 0;
  int fail_count = 0;
  int check_count = 0;

  always #5 mclk = ~mclk;

  dma_mode_chan uut
  (
    .MCLK(mclk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
    .RDATA(rdata), .EXT_REQUEST_PIN_B(req_b), .NMI(nmi), .STANDBY_B(standby_b),
    .REQ_ACK_PIN_B(ack_b), .REQ_ACK_OE_B(ack_oe_b), .XFER_END_PIN_B(end_b),
    .XFER_END_OE_B(end_oe_b), .BEAT(beat), .IRQ(irq)
  );

  ext_periph partner
  (
    .clk(mclk), .rst_b(rst_b), .go(go), .hold(hold), .ack_b(ack_b), .end_b(end_b),
    .req_b(req_b), .acks(acks), .ends(ends)
  );

  always @(posedge mclk)
  begin
    if (beat.strobe === 1'b1)
    begin
      beats <= beats + 1;
      last_src <= beat.src;
      last_dst <= beat.dst;
    end
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic pulse(input logic [7:0] h);
    @(posedge mclk);
    hold <= h;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask

  task automatic setup(input logic [31:0] n, input logic [31:0] s, input logic [31:0] blk);
    wr(dma_mode_pkg::OFS_SRC, s);
    wr(dma_mode_pkg::OFS_DST, s + 32'h0000_1000);
    wr(dma_mode_pkg::OFS_COUNT, n);
    wr(dma_mode_pkg::OFS_BLKSZ, blk);
    b0 = beats;
    a0 = acks;
    e0 = ends;
  endtask

  task automatic wait_beats(input int n);
    for (int i = 0; i < 200 && beats < n; i++)
      tick(1);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(dma_mode_pkg::OFS_CTRL);
    check("ctrl reset", d & 32'h0000_F800, 32'h0);
    check("oe reset", 32'({ack_oe_b, end_oe_b}), 32'h3);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0000_4000);
    rd(dma_mode_pkg::OFS_CTRL);
    check("flag set by write", 32'(d[14]), 32'h0);
    rd(8'h40);
    check("unmapped", d, 32'h0);
  endtask

  task automatic t_normal();
    setup(32'h1, 32'h0000_0100, 32'h1);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0000_B200);
    tick(4);
    check("oe on", 32'({ack_oe_b, end_oe_b}), 32'h0);
    check("no request", 32'(beats - b0), 32'h0);
    pulse(8'h02);
    wait_beats(b0 + 1);
    check("src", last_src, 32'h0000_0100);
    check("dst", last_dst, 32'h0000_1100);
    tick(3);
    check("ack", 32'(acks - a0), 32'h1);
    check("end", 32'(ends - e0), 32'h1);
    rd(dma_mode_pkg::OFS_ISTAT);
    check("istat end", 32'(d[0]), 32'h1);
    check("irq masked", 32'(irq), 32'h0);
    wr(dma_mode_pkg::OFS_IMASK, 32'h1);
    tick(2);
    check("irq on", 32'(irq), 32'h1);
    wr(dma_mode_pkg::OFS_ISTAT, 32'h1);
    tick(2);
    check("irq off", 32'(irq), 32'h0);
  endtask

  task automatic t_quiet();
    setup(32'h1, 32'h0000_0300, 32'h1);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0000_8200);
    pulse(8'h02);
    wait_beats(b0 + 1);
    tick(3);
    check("oe off", 32'({ack_oe_b, end_oe_b}), 32'h3);
    check("ack quiet", 32'(acks - a0), 32'h0);
    check("end quiet", 32'(ends - e0), 32'h0);
  endtask

  // request pin falls before enabling, so only level sensing can start the first move
  task automatic t_sense(input logic sel, input int exp);
    setup(32'h2, 32'h0000_0500, 32'h1);
    pulse(8'd40);
    wr(dma_mode_pkg::OFS_CTRL, sel ? 32'h0000_BA00 : 32'h0000_B200);
    tick(45);
    check("held low", 32'(beats - b0), 32'(exp));
    pulse(8'h02);
    tick(10);
    check("second", 32'(beats - b0), 32'h2);
  endtask

  task automatic t_abort();
    setup(32'h10, 32'h0000_1000, 32'h8);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0000_B300);
    pulse(8'h02);
    wait_beats(b0 + 1);
    @(posedge mclk);
    nmi <= 1'b1;
    @(posedge mclk);
    nmi <= 1'b0;
    tick(4);
    check("cut short", 32'(beats - b0 < 8), 32'h1);
    b0 = beats;
    wr(dma_mode_pkg::OFS_CTRL, 32'h0);
    rd(dma_mode_pkg::OFS_CTRL);
    check("flag kept", 32'(d[14]), 32'h1);
    check("active off", 32'(d[15]), 32'h0);
    rd(dma_mode_pkg::OFS_SRC);
    check("next src", d, last_src + 32'h4);
    rd(dma_mode_pkg::OFS_ISTAT);
    check("istat bef", 32'(d[1]), 32'h1);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0);
    rd(dma_mode_pkg::OFS_CTRL);
    check("flag clear", 32'(d[14]), 32'h0);
    check("stopped", 32'(beats - b0), 32'h0);
  endtask

  task automatic t_standby();
    setup(32'h4, 32'h0000_3000, 32'h1);
    wr(dma_mode_pkg::OFS_CTRL, 32'h0000_B200);
    @(posedge mclk);
    standby_b <= 1'b0;
    @(posedge mclk);
    standby_b <= 1'b1;
    rd(dma_mode_pkg::OFS_CTRL);
    check("standby", 32'(d[15]), 32'h0);
    pulse(8'h03);
    tick(10);
    check("idle", 32'(beats - b0), 32'h0);
  endtask

  task automatic close_out();
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #50us;
    fail_count++;
    close_out();
  end

  initial
  begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_normal();
    t_quiet();
    t_sense(1'b0, 2);
    t_sense(1'b1, 1);
    t_abort();
    t_standby();
    close_out();
  end
endmodule // dma_mode_chan_test
